// *** rtl/vxr_pkg.sv ***
package vxr_pkg;

    // ------------------------------------------------------------
    // Exit reason codes
    // ------------------------------------------------------------
    localparam logic [15:0] VXR_RSN_PCID_INV = 16'h003A;
    localparam logic [15:0] VXR_RSN_VM_FUNC = 16'h003B;
    localparam logic [15:0] VXR_RSN_ENCLAVE = 16'h003C;
    localparam logic [15:0] VXR_RSN_SEED = 16'h003D;
    localparam logic [15:0] VXR_RSN_LOG_FULL = 16'h003E;
    localparam logic [15:0] VXR_RSN_SSAVE = 16'h003F;
    localparam logic [15:0] VXR_RSN_SRESTORE = 16'h0040;
    localparam logic [15:0] VXR_RSN_SUBPAGE = 16'h0042;
    localparam logic [15:0] VXR_RSN_UWAIT = 16'h0043;
    localparam logic [15:0] VXR_RSN_TIMED_PAUSE = 16'h0044;
    localparam logic [15:0] VXR_RSN_WKEY = 16'h0045;

    // ------------------------------------------------------------
    // Limits
    // ------------------------------------------------------------
    localparam logic [31:0] VXR_ENCL_LEAF_CAP = 32'h0000003F;
    localparam logic [5:0] VXR_ENCL_CAP_BIT = 6'h3F;
    localparam logic [15:0] VXR_LOG_LAST = 16'h01FF;

    // ------------------------------------------------------------
    // Register map (word byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] VXR_A_CTRL = 8'h00;
    localparam logic [7:0] VXR_A_ENCL_LO = 8'h04;
    localparam logic [7:0] VXR_A_ENCL_HI = 8'h08;
    localparam logic [7:0] VXR_A_XSS_LO = 8'h0C;
    localparam logic [7:0] VXR_A_XSS_HI = 8'h10;
    localparam logic [7:0] VXR_A_MSR_LO = 8'h14;
    localparam logic [7:0] VXR_A_MSR_HI = 8'h18;
    localparam logic [7:0] VXR_A_STATUS = 8'h1C;
    localparam logic [7:0] VXR_A_COUNT = 8'h20;

    // Control bit positions
    localparam int VXR_C_PCID_EN = 0;
    localparam int VXR_C_INVLP_EX = 1;
    localparam int VXR_C_ENCL_EX = 2;
    localparam int VXR_C_SEED_EX = 3;
    localparam int VXR_C_SSR_EN = 4;
    localparam int VXR_C_UWP_EN = 5;
    localparam int VXR_C_TSC_EX = 6;
    localparam int VXR_C_WKEY_EX = 7;
    localparam logic [31:0] VXR_CTRL_RST = 32'h00000000;

    // ------------------------------------------------------------
    // Instruction kinds, one-hot except VXR_OP_NONE (zero)
    // ------------------------------------------------------------
    typedef enum logic [9:0] {
        VXR_OP_NONE = 10'h000,
        VXR_OP_PCID_INV = 10'h001,
        VXR_OP_VM_FUNC = 10'h002,
        VXR_OP_ENCLAVE = 10'h004,
        VXR_OP_SEED = 10'h008,
        VXR_OP_SSAVE = 10'h010,
        VXR_OP_SRESTORE = 10'h020,
        VXR_OP_UWAIT = 10'h040,
        VXR_OP_TIMED_PAUSE = 10'h080,
        VXR_OP_WKEY = 10'h100,
        VXR_OP_OTHER = 10'h200
    } vxr_op_e;

    // Event presented by the core pipeline
    typedef struct packed {
        logic valid;
        vxr_op_e op;
        logic [31:0] acc_lo;
        logic [31:0] dat_lo;
        logic func_enabled;
        logic func_cond;
        logic log_write;
        logic [15:0] log_index;
        logic subpage_check;
        logic subpage_miss;
        logic subpage_misconf;
    } vxr_evt_s;

    // Exit decision
    typedef struct packed {
        logic valid;
        logic do_exit;
        logic [15:0] reason;
    } vxr_exit_s;

endpackage : vxr_pkg

// *** rtl/vxr_mask_test.sv ***
// Tests a 64-bit triple AND for any set bit
module vxr_mask_test (
    input wire logic [63:0] a_i,
    input wire logic [63:0] b_i,
    input wire logic [63:0] c_i,
    output logic hit_o
);
    // ------------------------------------------------------------
    // Reduction
    // ------------------------------------------------------------
    always_comb begin
        hit_o = |(a_i & b_i & c_i);
    end
endmodule : vxr_mask_test

// *** rtl/vxr_wb_slave.sv ***
// Classic Wishbone slave: one-cycle ack, word registers
module vxr_wb_slave (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] rd_data_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic wr_stb_o,
    output logic [31:0] wr_data_o,
    output logic [7:0] wr_adr_o
);
    logic req;
    logic [31:0] mask;

    // ------------------------------------------------------------
    // Request and byte lane masking; unselected lanes are written as zero
    // ------------------------------------------------------------
    always_comb begin
        req = cyc_i && stb_i && !ack_o;
        mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
        wr_stb_o = req && we_i;
        wr_adr_o = adr_i;
        wr_data_o = dat_i & mask;
    end

    // Ack and read data one cycle after request
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= req;
            dat_o <= (req && !we_i) ? rd_data_i : 32'h00000000;
        end
    end
endmodule : vxr_wb_slave

// *** rtl/vxr_top.sv ***
// Contract
// [RULE1] pcid_invalidate_instr exits 58 when its enable and page-invalidate exiting set.
// [RULE2] vm_function_instr exits 59 if function disabled or raises its condition.
// [RULE3] Enclave exits 60 by leaf bitmap bit; leaves 63 up use bit 63.
// [RULE4] seed_read_instr exits 61 when its exiting control is set.
// [RULE5] page_mod_log write with index beyond 511 exits 62, no write.
// [RULE6] State save exits 63 when regs, mask msr and bitmap AND nonzero.
// [RULE7] State restore exits 64 when regs, mask msr and bitmap AND nonzero.
// [RULE8] subpage_permission miss or misconfiguration on write exits 66.
// [RULE9] user_monitor_wait_instr exits 67 with wait enable and timestamp exiting.
// [RULE10] timed_pause_instr exits 68 with wait enable and timestamp exiting.
// [RULE11] wrapping_key_load_instr exits 69 when its exiting control is set.
// [RULE12] Reason 65 never made; no condition means execute without exit.
module vxr_top (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire vxr_pkg::vxr_evt_s evt_i,
    output vxr_pkg::vxr_exit_s exit_o,
    output logic log_write_ok_o
);
    import vxr_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_ff;
    logic [63:0] encl_bmp_ff;
    logic [63:0] xss_bmp_ff;
    logic [63:0] mask_msr_ff;
    logic [15:0] last_reason_ff;
    logic last_exit_ff;
    logic [31:0] exit_count_ff;

    logic wr_stb;
    logic [31:0] wr_data;
    logic [7:0] wr_adr;
    logic [31:0] rd_data;

    logic nxt_exit;
    logic [15:0] nxt_reason;
    logic xss_hit;
    logic encl_hit;
    logic [5:0] encl_bit;
    logic [63:0] reg_pair;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    vxr_wb_slave u_wb (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .cyc_i(wb_cyc_i),
        .stb_i(wb_stb_i),
        .we_i(wb_we_i),
        .adr_i(wb_adr_i),
        .sel_i(wb_sel_i),
        .dat_i(wb_dat_i),
        .rd_data_i(rd_data),
        .dat_o(wb_dat_o),
        .ack_o(wb_ack_o),
        .wr_stb_o(wr_stb),
        .wr_data_o(wr_data),
        .wr_adr_o(wr_adr)
    );

    // Register writes; unmapped addresses are ignored
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_ff <= VXR_CTRL_RST;
            encl_bmp_ff <= 64'h0000000000000000;
            xss_bmp_ff <= 64'h0000000000000000;
            mask_msr_ff <= 64'h0000000000000000;
        end else if (wr_stb) begin
            case (wr_adr)
                VXR_A_CTRL: ctrl_ff <= wr_data;
                VXR_A_ENCL_LO: encl_bmp_ff[31:0] <= wr_data;
                VXR_A_ENCL_HI: encl_bmp_ff[63:32] <= wr_data;
                VXR_A_XSS_LO: xss_bmp_ff[31:0] <= wr_data;
                VXR_A_XSS_HI: xss_bmp_ff[63:32] <= wr_data;
                VXR_A_MSR_LO: mask_msr_ff[31:0] <= wr_data;
                VXR_A_MSR_HI: mask_msr_ff[63:32] <= wr_data;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        case (wb_adr_i)
            VXR_A_CTRL: rd_data = ctrl_ff;
            VXR_A_ENCL_LO: rd_data = encl_bmp_ff[31:0];
            VXR_A_ENCL_HI: rd_data = encl_bmp_ff[63:32];
            VXR_A_XSS_LO: rd_data = xss_bmp_ff[31:0];
            VXR_A_XSS_HI: rd_data = xss_bmp_ff[63:32];
            VXR_A_MSR_LO: rd_data = mask_msr_ff[31:0];
            VXR_A_MSR_HI: rd_data = mask_msr_ff[63:32];
            VXR_A_STATUS: rd_data = {15'h0000, last_exit_ff, last_reason_ff};
            VXR_A_COUNT: rd_data = exit_count_ff;
            default: rd_data = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------
    // Condition evaluation
    // ------------------------------------------------------------
    assign reg_pair = {evt_i.dat_lo, evt_i.acc_lo};

    // [RULE6] State mask AND
    vxr_mask_test u_xss (
        .a_i(reg_pair),
        .b_i(mask_msr_ff),
        .c_i(xss_bmp_ff),
        .hit_o(xss_hit)
    );

    // [RULE3] Leaf bit select
    always_comb begin
        if (evt_i.acc_lo < VXR_ENCL_LEAF_CAP) begin
            encl_bit = evt_i.acc_lo[5:0];
        end else begin
            encl_bit = VXR_ENCL_CAP_BIT;
        end
        encl_hit = encl_bmp_ff[encl_bit];
    end

    // Reason selection per event; log-full and sub-page events take priority
    always_comb begin
        nxt_exit = 1'b0;
        nxt_reason = 16'h0000;
        if (evt_i.log_write && (evt_i.log_index > VXR_LOG_LAST)) begin
            // [RULE5] Log index overflow
            nxt_exit = 1'b1;
            nxt_reason = VXR_RSN_LOG_FULL;
        end else if (evt_i.subpage_check
            && (evt_i.subpage_miss || evt_i.subpage_misconf)) begin
            // [RULE8] Sub-page permission event
            nxt_exit = 1'b1;
            nxt_reason = VXR_RSN_SUBPAGE;
        end else begin
            // [RULE12] Default is no exit, 65 never chosen
            case (evt_i.op)
                VXR_OP_PCID_INV: begin
                    // [RULE1] Both controls set
                    nxt_exit = ctrl_ff[VXR_C_PCID_EN] && ctrl_ff[VXR_C_INVLP_EX];
                    nxt_reason = VXR_RSN_PCID_INV;
                end
                VXR_OP_VM_FUNC: begin
                    // [RULE2] Disabled or function condition
                    nxt_exit = !evt_i.func_enabled || evt_i.func_cond;
                    nxt_reason = VXR_RSN_VM_FUNC;
                end
                VXR_OP_ENCLAVE: begin
                    // [RULE3] Enclave exiting and bitmap hit
                    nxt_exit = ctrl_ff[VXR_C_ENCL_EX] && encl_hit;
                    nxt_reason = VXR_RSN_ENCLAVE;
                end
                VXR_OP_SEED: begin
                    // [RULE4] Seed exiting control
                    nxt_exit = ctrl_ff[VXR_C_SEED_EX];
                    nxt_reason = VXR_RSN_SEED;
                end
                VXR_OP_SSAVE: begin
                    // [RULE6] Enable and mask hit
                    nxt_exit = ctrl_ff[VXR_C_SSR_EN] && xss_hit;
                    nxt_reason = VXR_RSN_SSAVE;
                end
                VXR_OP_SRESTORE: begin
                    // [RULE7] Enable and mask hit
                    nxt_exit = ctrl_ff[VXR_C_SSR_EN] && xss_hit;
                    nxt_reason = VXR_RSN_SRESTORE;
                end
                VXR_OP_UWAIT: begin
                    // [RULE9] Wait enable and timestamp exiting
                    nxt_exit = ctrl_ff[VXR_C_UWP_EN] && ctrl_ff[VXR_C_TSC_EX];
                    nxt_reason = VXR_RSN_UWAIT;
                end
                VXR_OP_TIMED_PAUSE: begin
                    // [RULE10] Wait enable and timestamp exiting
                    nxt_exit = ctrl_ff[VXR_C_UWP_EN] && ctrl_ff[VXR_C_TSC_EX];
                    nxt_reason = VXR_RSN_TIMED_PAUSE;
                end
                VXR_OP_WKEY: begin
                    // [RULE11] Key load exiting control
                    nxt_exit = ctrl_ff[VXR_C_WKEY_EX];
                    nxt_reason = VXR_RSN_WKEY;
                end
                default: begin
                    nxt_exit = 1'b0;
                    nxt_reason = 16'h0000;
                end
            endcase
            if (!nxt_exit) begin
                nxt_reason = 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Exit decision, one cycle after the event
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            exit_o <= '0;
            log_write_ok_o <= 1'b0;
        end else begin
            exit_o.valid <= evt_i.valid;
            exit_o.do_exit <= evt_i.valid && nxt_exit;
            exit_o.reason <= evt_i.valid ? nxt_reason : 16'h0000;
            // [RULE5] Write only when index in range
            log_write_ok_o <= evt_i.valid && evt_i.log_write
                && (evt_i.log_index <= VXR_LOG_LAST);
        end
    end

    // Status capture of last exit and exit count
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            last_reason_ff <= 16'h0000;
            last_exit_ff <= 1'b0;
            exit_count_ff <= 32'h00000000;
        end else if (evt_i.valid && nxt_exit) begin
            last_reason_ff <= nxt_reason;
            last_exit_ff <= 1'b1;
            exit_count_ff <= exit_count_ff + 32'h00000001;
        end
    end
endmodule : vxr_top

// *** tb/vxr_top_properties.sv ***
// ------------------------------------------------------------
// Port checker for the exit reason encoder
// ------------------------------------------------------------
module vxr_top_properties (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire vxr_pkg::vxr_evt_s evt_i,
    input wire vxr_pkg::vxr_exit_s exit_o,
    input wire logic log_write_ok_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import vxr_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic full;
    logic subpage_hit;
    // Event qualifiers for log-full and sub-page faults
    assign full = evt_i.valid && evt_i.log_write
        && evt_i.log_index > VXR_LOG_LAST;
    assign subpage_hit = evt_i.valid && evt_i.subpage_check
        && (evt_i.subpage_miss || evt_i.subpage_misconf);
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("bus request not acked");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    chk_exit_follow: assert property (evt_i.valid |=> exit_o.valid)
        else $error("event gave no decision");
    chk_exit_quiet: assert property (!evt_i.valid |=> !exit_o.valid)
        else $error("decision without event");
    chk_log_full: assert property (
        full |=> exit_o.do_exit && exit_o.reason == VXR_RSN_LOG_FULL
        && !log_write_ok_o) else $error("log full not reported");
    chk_log_ok: assert property (
        evt_i.valid && evt_i.log_write && !full |=> log_write_ok_o)
        else $error("log write refused");
    chk_subpage_exit: assert property (
        subpage_hit && !full |=> exit_o.reason == VXR_RSN_SUBPAGE)
        else $error("sub-page fault not reported");
    chk_vm_func_exit: assert property (
        evt_i.valid && evt_i.op == VXR_OP_VM_FUNC && !evt_i.log_write
        && !evt_i.subpage_check && (!evt_i.func_enabled || evt_i.func_cond)
        |=> exit_o.do_exit && exit_o.reason == VXR_RSN_VM_FUNC)
        else $error("function exit missing");
    chk_plain_op: assert property (
        evt_i.valid && evt_i.op == VXR_OP_OTHER && !evt_i.log_write
        && !evt_i.subpage_check |=> !exit_o.do_exit && exit_o.reason == 16'h0)
        else $error("unexpected exit");
    chk_no_65: assert property (
        exit_o.do_exit |-> exit_o.valid && exit_o.reason != 16'h0041)
        else $error("bad exit reason");
    chk_quiet_reason: assert property (
        exit_o.valid && !exit_o.do_exit |-> exit_o.reason == 16'h0000)
        else $error("reason without exit");
endmodule : vxr_top_properties

// *** tb/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import vxr_pkg::*;
    logic clk_sys_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic log_write_ok_o;
    vxr_evt_s evt_i, e;
    vxr_exit_s exit_o;
    int failures, comparisons, cycles, exits;

    vxr_top dut_u (.clk_sys_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .evt_i,
        .exit_o, .log_write_ok_o);

    // Clock and hang guard
    initial begin
        clk_sys_i = 0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task stop_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
            input logic [3:0] sel = 4'hF);
        @(posedge clk_sys_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        {wb_adr_i, wb_dat_i, wb_sel_i} <= {adr, dat, sel};
        // Hold the request until ack is sampled high at a rising edge
        do begin
            @(posedge clk_sys_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb

    function vxr_evt_s mk(vxr_op_e op, logic [31:0] a, logic [31:0] d);
        mk = '0;
        mk.valid = 1'b1;
        mk.op = op;
        mk.acc_lo = a;
        mk.dat_lo = d;
    endfunction : mk

    task ev(input vxr_evt_s x, input logic [15:0] rsn);
        @(posedge clk_sys_i) evt_i <= x;
        @(posedge clk_sys_i) evt_i <= '0;
        #1;
        // Running tally of exits for the count register
        if (rsn != 16'h0) exits++;
        check({15'h0, exit_o.valid, 15'h0, exit_o.do_exit},
            {16'h1, 15'h0, rsn != 16'h0});
        check({16'h0, exit_o.reason}, {16'h0, rsn});
        check({31'h0, log_write_ok_o},
            {31'h0, x.log_write && x.log_index <= VXR_LOG_LAST});
    endtask : ev

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_regs();
        wb(0, VXR_A_CTRL, 0);
        check(rd, VXR_CTRL_RST);
        wb(0, VXR_A_STATUS, 0);
        check(rd, 32'h0);
        wb(0, VXR_A_COUNT, 0);
        check(rd, 32'h0);
        wb(1, VXR_A_ENCL_HI, 32'hA5A5A5A5, 4'h5);
        wb(0, VXR_A_ENCL_HI, 0);
        check(rd, 32'h00A500A5);
        wb(1, 8'h24, 32'hFFFFFFFF);
        wb(0, 8'h24, 0);
        check(rd, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_gated();
        vxr_op_e op[5] = '{VXR_OP_PCID_INV, VXR_OP_SEED, VXR_OP_UWAIT,
            VXR_OP_TIMED_PAUSE, VXR_OP_WKEY};
        logic [7:0] m[5] = '{8'h03, 8'h08, 8'h60, 8'h60, 8'h80};
        logic [15:0] r[5] = '{VXR_RSN_PCID_INV, VXR_RSN_SEED, VXR_RSN_UWAIT,
            VXR_RSN_TIMED_PAUSE, VXR_RSN_WKEY};
        for (int i = 0; i < 5; i++) begin
            wb(1, VXR_A_CTRL, {24'h0, ~m[i]});
            ev(mk(op[i], 0, 0), 16'h0);
            wb(1, VXR_A_CTRL, {24'h0, m[i] & (m[i] - 8'h1)});
            ev(mk(op[i], 0, 0), 16'h0);
            wb(1, VXR_A_CTRL, {24'h0, m[i]});
            ev(mk(op[i], 0, 0), r[i]);
        end
        $display("test gated done");
    endtask : t_gated

    task t_encl();
        wb(1, VXR_A_CTRL, 32'h4);
        wb(1, VXR_A_ENCL_LO, 32'h20);
        wb(1, VXR_A_ENCL_HI, 32'h80000000);
        ev(mk(VXR_OP_ENCLAVE, 5, 0), VXR_RSN_ENCLAVE);
        ev(mk(VXR_OP_ENCLAVE, 6, 0), 16'h0);
        ev(mk(VXR_OP_ENCLAVE, 63, 0), VXR_RSN_ENCLAVE);
        wb(1, VXR_A_ENCL_HI, 32'h7FFFFFFF);
        ev(mk(VXR_OP_ENCLAVE, 62, 0), VXR_RSN_ENCLAVE);
        ev(mk(VXR_OP_ENCLAVE, 63, 0), 16'h0);
        ev(mk(VXR_OP_ENCLAVE, 32'h80000005, 0), 16'h0);
        wb(1, VXR_A_CTRL, 32'h0);
        ev(mk(VXR_OP_ENCLAVE, 5, 0), 16'h0);
        $display("test enclave done");
    endtask : t_encl

    task t_state();
        wb(1, VXR_A_CTRL, 32'h10);
        wb(1, VXR_A_XSS_LO, 32'h0C);
        wb(1, VXR_A_MSR_LO, 32'h0A);
        wb(1, VXR_A_XSS_HI, 32'h1);
        wb(1, VXR_A_MSR_HI, 32'h1);
        ev(mk(VXR_OP_SSAVE, 8, 0), VXR_RSN_SSAVE);
        ev(mk(VXR_OP_SSAVE, 4, 0), 16'h0);
        ev(mk(VXR_OP_SRESTORE, 2, 0), 16'h0);
        ev(mk(VXR_OP_SRESTORE, 0, 1), VXR_RSN_SRESTORE);
        wb(1, VXR_A_CTRL, 32'h0);
        ev(mk(VXR_OP_SSAVE, 8, 1), 16'h0);
        $display("test state done");
    endtask : t_state

    task t_misc();
        e = mk(VXR_OP_VM_FUNC, 0, 0);
        ev(e, VXR_RSN_VM_FUNC);
        e.func_enabled = 1'b1;
        ev(e, 16'h0);
        e.func_cond = 1'b1;
        ev(e, VXR_RSN_VM_FUNC);
        ev(mk(VXR_OP_OTHER, 0, 0), 16'h0);
        e = mk(VXR_OP_NONE, 0, 0);
        {e.log_write, e.log_index} = {1'b1, 16'h01FF};
        ev(e, 16'h0);
        e.log_index = 16'h0200;
        ev(e, VXR_RSN_LOG_FULL);
        {e.subpage_check, e.subpage_miss} = 2'b11;
        ev(e, VXR_RSN_LOG_FULL);
        e.log_write = 1'b0;
        ev(e, VXR_RSN_SUBPAGE);
        e.subpage_miss = 1'b0;
        ev(e, 16'h0);
        wb(1, VXR_A_CTRL, 32'h8);
        e.op = VXR_OP_SEED;
        e.subpage_misconf = 1'b1;
        ev(e, VXR_RSN_SUBPAGE);
        // Status holds the last exit, count holds every exit seen
        wb(0, VXR_A_STATUS, 0);
        check(rd, {15'h0, 1'b1, VXR_RSN_SUBPAGE});
        wb(0, VXR_A_COUNT, 0);
        check(rd, exits);
        $display("test misc done");
    endtask : t_misc

    // Reset, then the scenarios
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
        {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        evt_i = '0;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 0;
        t_regs();
        t_gated();
        t_encl();
        t_state();
        t_misc();
        stop_test();
    end
endmodule : tb_top

bind vxr_top vxr_top_properties chk_u (.clk_sys_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .evt_i, .exit_o, .log_write_ok_o);
